// >>> rtl/bfe_pkg.sv
// package with register map, field positions and timing for fault/event logic
// How it works
// - limit setup bits 5:3 pick input current limit, applied during soft-start
// - over-current opens blocking switch, enters buck, sets event bit 6
// - bus short in normal run opens switch, buck at max peak, sets status 2
// - bus below 90% of input after soft-start pre-POR: flag, wait 2 ss, retry
// - storage check starts 56 ms into pre-charge; short if below 0.7 V
// - storage short opens storage switch, stops converter, sets event bit 5
// - storage short latches converter off until por-falling or disable/enable
// - fast charge: short if storage below 0.7 V or below bus minus 0.2 V
// - no short check during measurement; no drop check in buck mode
// - reverse current with enable bit 6 set: open, buck, clear status 0, bit 4
// - storage over threshold field stops boost, sets status 3, no event flag or interrupt
// - boost resumes once storage fell 1 V below over-voltage threshold
// - junction above 125 C sets event bit 1 and interrupts
// - warning clear by writing 1 honoured only below 100 C
// - junction at 150 C sets event bit 0 and interrupts
// - shutdown: status 4 set turns all off, else buck down to buck-off
// - recover below 125 C; shutdown flag clear honoured only below 125 C
// - all control registers load fixed defaults at reset, host may rewrite
// - input over-voltage enabled by limit bit 7: bit 7, open switch, buck
// - storage short drives storage power good low
// - measurement done sets bit 3, conversion done sets bit 2, no action
// - bus power good held low whenever in buck mode
// - interrupt high on unmasked event until host clears all
package bfe_pkg;
    localparam logic [7:0] LIMIT_SETUP_OFS = 8'h00;
    localparam logic [7:0] SYSTEM_STATUS_OFS = 8'h04;
    localparam logic [7:0] SPECIAL_FUNCTION_OFS = 8'h08;
    localparam logic [7:0] EVENT_FLAG_OFS = 8'h0c;
    localparam logic [7:0] EVENT_MASK_OFS = 8'h10;
    localparam logic [7:0] OV_THRESHOLD_OFS = 8'h14;
    localparam logic [7:0] LIMIT_SETUP_RST = 8'h01;
    localparam logic [7:0] SYSTEM_STATUS_RST = 8'h00;
    localparam logic [7:0] SPECIAL_FUNCTION_RST = 8'h00;
    localparam logic [7:0] EVENT_MASK_RST = 8'hff;
    localparam logic [4:0] OV_THRESHOLD_RST = 5'h1f;
    localparam int LSP_OVP_EN_BIT = 7;
    localparam int LSP_ENA_BIT = 0;
    localparam int SYS_RB_ON_BIT = 0;
    localparam int SYS_BUS_FAIL_BIT = 2;
    localparam int SYS_STR_OV_BIT = 3;
    localparam int SYS_TSD_MODE_BIT = 4;
    localparam int SF_RB_EN_BIT = 6;
    localparam int EV_TSD = 0;
    localparam int EV_TWARN = 1;
    localparam int EV_ADC = 2;
    localparam int EV_MEAS = 3;
    localparam int EV_RBP = 4;
    localparam int EV_SCP = 5;
    localparam int EV_OCP = 6;
    localparam int EV_OVP = 7;
    localparam int CLK_MHZ = 25;
    localparam int PRECHARGE_CHECK_MS = 56;
    localparam int PRECHARGE_CHECK_CYC = PRECHARGE_CHECK_MS * CLK_MHZ * 1000;
    localparam int SOFT_START_TIME_MS = 1;
    localparam int SOFT_START_CYC = SOFT_START_TIME_MS * CLK_MHZ * 1000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        BFE_OFF, BFE_SOFT_START, BFE_RETRY_WAIT, BFE_PRECHARGE,
        BFE_RUN, BFE_BUCK, BFE_LATCHED, BFE_SHUTDOWN
    } bfe_state_type;
endpackage : bfe_pkg

// >>> rtl/bfe_fault_ctrl.sv
// fault protection, sticky event flags and axi4-lite registers
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bfe_fault_ctrl
    import bfe_pkg::*;
#(
    parameter int PRECHARGE_CYC = PRECHARGE_CHECK_CYC,
    parameter int SS_CYC = SOFT_START_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ena_pin,
    input wire logic in_ocp_cmp,
    input wire logic in_ovp_cmp,
    input wire logic bus_short_cmp,
    input wire logic bus_low_cmp,
    input wire logic rev_current_cmp,
    input wire logic str_low_cmp,
    input wire logic str_drop_cmp,
    input wire logic str_ov_cmp,
    input wire logic str_ov_release_cmp,
    input wire logic str_buck_off_cmp,
    input wire logic bus_por_fall_cmp,
    input wire logic tj_125_cmp,
    input wire logic tj_100_cmp,
    input wire logic tj_150_cmp,
    input wire logic por_done_in,
    input wire logic meas_active_in,
    input wire logic meas_done_in,
    input wire logic adc_done_in,
    output logic reverse_blocking_switch,
    output logic storage_disconnect_switch,
    output logic buck_mode,
    output logic buck_max_peak,
    output logic boost_en,
    output logic [2:0] input_current_limit,
    output logic current_ramp,
    output logic [4:0] storage_overvoltage_threshold,
    output logic all_off,
    output logic bus_power_good,
    output logic storage_power_good,
    output logic int_out
);
    localparam int NS = 15;
    // comparator and status inputs, all from the analog side
    logic [NS-1:0] raw_in, sync1_q, sync2_q;
    assign raw_in = {ena_pin, in_ocp_cmp, in_ovp_cmp, bus_short_cmp,
        bus_low_cmp, rev_current_cmp, str_low_cmp, str_drop_cmp,
        str_ov_cmp, str_ov_release_cmp, str_buck_off_cmp,
        bus_por_fall_cmp, tj_125_cmp, tj_100_cmp, tj_150_cmp};
    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end
    logic s_ena, s_ocp, s_ovp, s_bshort, s_blow, s_rev, s_slow, s_sdrop;
    logic s_sov, s_sovrel, s_bkoff, s_porf, s_t125, s_t100, s_t150;
    assign {s_ena, s_ocp, s_ovp, s_bshort, s_blow, s_rev, s_slow, s_sdrop,
        s_sov, s_sovrel, s_bkoff, s_porf, s_t125, s_t100, s_t150} = sync2_q;
    // digital-side pulses need one flop to line up, no synchroniser
    logic por_q, meas_act_q, meas_q, adc_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {por_q, meas_act_q, meas_q, adc_q} <= '0;
        end else begin
            {por_q, meas_act_q, meas_q, adc_q} <=
                {por_done_in, meas_active_in, meas_done_in, adc_done_in};
        end
    end

    // register file
    logic [7:0] lsp_q, lsp_d, sys_q, sys_d, sf_q, sf_d, flag_q, flag_d;
    logic [7:0] mask_q, mask_d;
    logic [4:0] ovt_q, ovt_d;
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic [7:0] ev_set, clr_req;
    logic sys_bus_set, sys_ov_set, rb_clear, rb_set;
    logic wr_go, rd_go;
    assign wr_go = aw_q && w_q && !bv_q;
    assign rd_go = s_axi_arvalid && !rv_q;

    // bus slave and register writes
    always_comb begin
        lsp_d = lsp_q;
        sf_d = sf_q;
        mask_d = mask_q;
        ovt_d = ovt_q;
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        clr_req = '0;
        sys_d = sys_q;
        if (s_axi_awvalid && !aw_q) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
            if (!s_axi_wstrb[0]) begin
                wd_d[7:0] = 8'h00;
            end
        end
        if (wr_go) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = RESP_OKAY;
            unique case (awa_q)
                LIMIT_SETUP_OFS: lsp_d = wd_q[7:0];
                SYSTEM_STATUS_OFS: sys_d[7:4] = wd_q[7:4];
                SPECIAL_FUNCTION_OFS: sf_d = wd_q[7:0];
                EVENT_FLAG_OFS: clr_req = wd_q[7:0];
                EVENT_MASK_OFS: mask_d = wd_q[7:0];
                OV_THRESHOLD_OFS: ovt_d = wd_q[4:0];
                default: br_d = RESP_SLVERR;
            endcase
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        if (rd_go) begin
            rv_d = 1'b1;
            rr_d = RESP_OKAY;
            rd_d = '0;
            unique case (s_axi_araddr)
                LIMIT_SETUP_OFS: rd_d[7:0] = lsp_q;
                SYSTEM_STATUS_OFS: rd_d[7:0] = sys_q;
                SPECIAL_FUNCTION_OFS: rd_d[7:0] = sf_q;
                EVENT_FLAG_OFS: rd_d[7:0] = flag_q;
                EVENT_MASK_OFS: rd_d[7:0] = mask_q;
                OV_THRESHOLD_OFS: rd_d[4:0] = ovt_q;
                default: rr_d = RESP_SLVERR;
            endcase
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
        // hardware status bits; set beats host clear, rb_clear beats rb_set
        if (sys_bus_set) sys_d[SYS_BUS_FAIL_BIT] = 1'b1;
        if (sys_ov_set) sys_d[SYS_STR_OV_BIT] = 1'b1;
        if (rb_set) sys_d[SYS_RB_ON_BIT] = 1'b1;
        if (rb_clear) sys_d[SYS_RB_ON_BIT] = 1'b0;
        if (wr_go && awa_q == SYSTEM_STATUS_OFS) begin
            sys_d[SYS_BUS_FAIL_BIT] = sys_bus_set;
            sys_d[SYS_STR_OV_BIT] = sys_ov_set;
        end
    end
    // temperature-gated clears for the thermal flags
    logic [7:0] clr_ok;
    always_comb begin
        clr_ok = clr_req;
        clr_ok[EV_TWARN] = clr_req[EV_TWARN] && s_t100;
        clr_ok[EV_TSD] = clr_req[EV_TSD] && !s_t125;
        flag_d = (flag_q & ~clr_ok) | ev_set;
    end

    // protection state machine
    bfe_state_type st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic ov_stop_q, ov_stop_d, max_pk_q, max_pk_d;
    logic enabled, rb_fault, ov_fault, tsd_hit;
    assign enabled = s_ena && lsp_q[LSP_ENA_BIT];
    assign ov_fault = s_ovp && lsp_q[LSP_OVP_EN_BIT];
    assign rb_fault = s_rev && sf_q[SF_RB_EN_BIT];
    assign tsd_hit = s_t150 && !flag_q[EV_TSD];
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 32'd1;
        ov_stop_d = ov_stop_q;
        max_pk_d = max_pk_q;
        ev_set = '0;
        sys_bus_set = 1'b0;
        sys_ov_set = 1'b0;
        rb_clear = 1'b0;
        rb_set = 1'b0;
        ev_set[EV_MEAS] = meas_q;
        ev_set[EV_ADC] = adc_q;
        ev_set[EV_TWARN] = s_t125;
        ev_set[EV_TSD] = s_t150;
        // boost over-voltage hysteresis
        if (s_sov) begin
            ov_stop_d = 1'b1;
            sys_ov_set = !ov_stop_q;
        end else if (s_sovrel) begin
            ov_stop_d = 1'b0;
        end
        unique case (st_q)
            BFE_OFF: begin
                cnt_d = '0;
                max_pk_d = 1'b0;
                if (enabled && !s_t125) st_d = BFE_SOFT_START;
            end
            BFE_SOFT_START: begin
                if (cnt_q >= 32'(SS_CYC - 1)) begin
                    cnt_d = '0;
                    if (s_blow && !por_q) begin
                        sys_bus_set = 1'b1;
                        st_d = BFE_RETRY_WAIT;
                    end else begin
                        rb_set = 1'b1;
                        st_d = BFE_PRECHARGE;
                    end
                end
            end
            BFE_RETRY_WAIT: begin
                if (cnt_q >= 32'(2 * SS_CYC - 1)) begin
                    cnt_d = '0;
                    st_d = BFE_SOFT_START;
                end
            end
            BFE_PRECHARGE: begin
                if (cnt_q >= 32'(PRECHARGE_CYC - 1)) begin
                    cnt_d = cnt_q;
                    if (s_slow && !meas_act_q) begin
                        ev_set[EV_SCP] = 1'b1;
                        st_d = BFE_LATCHED;
                    end else begin
                        st_d = BFE_RUN;
                    end
                end
            end
            BFE_RUN: begin
                // fast charge short check, suppressed while measuring
                if (!meas_act_q && (s_slow || s_sdrop)) begin
                    ev_set[EV_SCP] = 1'b1;
                    st_d = BFE_LATCHED;
                end else if (s_bshort) begin
                    sys_bus_set = 1'b1;
                    max_pk_d = 1'b1;
                    st_d = BFE_BUCK;
                end
            end
            BFE_BUCK: begin
                // drop check off in buck; only the low level counts
                if (!meas_act_q && s_slow) begin
                    ev_set[EV_SCP] = 1'b1;
                    st_d = BFE_LATCHED;
                end else if (!s_ocp && !ov_fault && !rb_fault && !s_bshort
                        && !s_t150
                        && !(flag_q[EV_TSD] && s_t125)) begin
                    max_pk_d = 1'b0;
                    cnt_d = '0;
                    st_d = BFE_SOFT_START;
                end
            end
            BFE_LATCHED: begin
                if (s_porf || !enabled) st_d = BFE_OFF;
            end
            BFE_SHUTDOWN: begin
                if (!s_t125) st_d = BFE_OFF;
            end
        endcase
        // faults that force buck from soft-start, pre-charge and run
        if (st_q inside {BFE_SOFT_START, BFE_PRECHARGE, BFE_RUN}) begin
            if (s_ocp) begin
                ev_set[EV_OCP] = 1'b1;
                st_d = BFE_BUCK;
            end
            if (ov_fault) begin
                ev_set[EV_OVP] = 1'b1;
                st_d = BFE_BUCK;
            end
            if (rb_fault) begin
                ev_set[EV_RBP] = 1'b1;
                st_d = BFE_BUCK;
            end
        end
        if (st_q != BFE_OFF && st_d == BFE_BUCK && st_q != BFE_BUCK) begin
            rb_clear = 1'b1;
        end
        // a latched storage short stays latched even on overheat
        if (tsd_hit && !(st_q inside {BFE_SHUTDOWN, BFE_LATCHED})) begin
            rb_clear = 1'b1;
            st_d = sys_q[SYS_TSD_MODE_BIT] ? BFE_SHUTDOWN : BFE_BUCK;
        end
        if (!enabled && st_q != BFE_LATCHED) st_d = BFE_OFF;
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lsp_q <= LIMIT_SETUP_RST;
            sys_q <= SYSTEM_STATUS_RST;
            sf_q <= SPECIAL_FUNCTION_RST;
            flag_q <= '0;
            mask_q <= EVENT_MASK_RST;
            ovt_q <= OV_THRESHOLD_RST;
            {aw_q, w_q, bv_q, rv_q} <= '0;
            awa_q <= '0;
            wd_q <= '0;
            rd_q <= '0;
            br_q <= '0;
            rr_q <= '0;
            st_q <= BFE_OFF;
            cnt_q <= '0;
            ov_stop_q <= 1'b0;
            max_pk_q <= 1'b0;
        end else begin
            lsp_q <= lsp_d;
            sys_q <= sys_d;
            sf_q <= sf_d;
            flag_q <= flag_d;
            mask_q <= mask_d;
            ovt_q <= ovt_d;
            {aw_q, w_q, bv_q, rv_q} <= {aw_d, w_d, bv_d, rv_d};
            awa_q <= awa_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            br_q <= br_d;
            rr_q <= rr_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            ov_stop_q <= ov_stop_d;
            max_pk_q <= max_pk_d;
        end
    end
    // registered outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reverse_blocking_switch <= 1'b0;
            storage_disconnect_switch <= 1'b0;
            buck_mode <= 1'b0;
            buck_max_peak <= 1'b0;
            boost_en <= 1'b0;
            current_ramp <= 1'b0;
            all_off <= 1'b1;
            bus_power_good <= 1'b0;
            storage_power_good <= 1'b0;
            int_out <= 1'b0;
            input_current_limit <= LIMIT_SETUP_RST[5:3];
            storage_overvoltage_threshold <= OV_THRESHOLD_RST;
        end else begin
            reverse_blocking_switch <= st_d inside
                {BFE_SOFT_START, BFE_PRECHARGE, BFE_RUN};
            storage_disconnect_switch <= st_d inside
                {BFE_PRECHARGE, BFE_RUN, BFE_BUCK};
            buck_mode <= st_d == BFE_BUCK
                && !(flag_q[EV_TSD] && s_bkoff);
            buck_max_peak <= max_pk_d;
            boost_en <= st_d inside {BFE_PRECHARGE, BFE_RUN}
                && !ov_stop_d;
            current_ramp <= st_d == BFE_SOFT_START;
            all_off <= st_d inside {BFE_OFF, BFE_SHUTDOWN};
            bus_power_good <= st_d == BFE_RUN;
            storage_power_good <= st_d != BFE_LATCHED
                && st_d != BFE_OFF;
            int_out <= |(flag_d & ~mask_d);
            input_current_limit <= lsp_d[5:3];
            storage_overvoltage_threshold <= ovt_d;
        end
    end
    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;

    default clocking dc @(posedge core_clk); endclocking
    default disable iff (rst);
    ocp_flag_a: assert property ((st_q == BFE_RUN && s_ocp) |=>
        flag_q[EV_OCP] && !reverse_blocking_switch)
        else $error("ocp did not flag or open switch");
    scp_latch_a: assert property ((st_q == BFE_LATCHED && enabled && !s_porf)
        |=> st_q == BFE_LATCHED)
        else $error("storage short latch released early");
    scp_pg_a: assert property (st_q == BFE_LATCHED |=>
        !storage_power_good && !storage_disconnect_switch)
        else $error("storage short outputs wrong");
    buck_pg_a: assert property (buck_mode |-> !bus_power_good)
        else $error("bus power good high in buck");
    warn_clr_a: assert property ((flag_q[EV_TWARN] && !s_t100) |=>
        flag_q[EV_TWARN])
        else $error("warning cleared while hot");
    tsd_clr_a: assert property ((flag_q[EV_TSD] && s_t125) |=>
        flag_q[EV_TSD])
        else $error("shutdown flag cleared while hot");
    int_mask_a: assert property (int_out == (|(flag_q & ~mask_q)))
        else $error("interrupt does not match pending events");
    rbp_off_a: assert property ((!sf_q[SF_RB_EN_BIT] && !flag_q[EV_RBP])
        |=> !flag_q[EV_RBP])
        else $error("reverse flag set while disabled");
    ov_stop_a: assert property (s_sov |=> !boost_en)
        else $error("boost not stopped on storage over-voltage");
    retry_c: cover property (st_q == BFE_RETRY_WAIT ##1 st_q == BFE_SOFT_START);
    latch_c: cover property (st_q == BFE_LATCHED);
    shut_c: cover property (st_q == BFE_SHUTDOWN);
    int_c: cover property ($rose(int_out));
endmodule : bfe_fault_ctrl
`default_nettype wire

// >>> dv/bfe_host.sv
// host model: axi4-lite master that reads and clears the event flags
`timescale 1ns/1ps
`default_nettype none
module bfe_host (
    input wire logic clk,
    output var logic [7:0] awaddr,
    output var logic awvalid,
    input wire logic awready,
    output var logic [31:0] wdata,
    output var logic [3:0] wstrb,
    output var logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output var logic bready,
    output var logic [7:0] araddr,
    output var logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output var logic rready
);
    // idle bus at time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, wstrb, araddr} = '0;
    end

    // one write; released payload is inverted so stale data never matches
    task automatic write(input logic [7:0] a, input logic [31:0] v,
                         output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hf;
        {awvalid, wvalid} <= 2'b11;
        fork
            begin
                do @(negedge clk); while (!awready);
                @(posedge clk);
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            begin
                do @(negedge clk); while (!wready);
                @(posedge clk);
                wvalid <= 1'b0;
                wdata <= ~v;
            end
        join
        bready <= 1'b1;
        do @(negedge clk); while (!bvalid);
        r = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask : write

    // one read; ready is sampled mid-cycle, where it is settled
    task automatic read(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(negedge clk); while (!rvalid);
        v = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask : read
endmodule : bfe_host
`default_nettype wire

// >>> dv/backup_fault_event_logic_bench.sv
// self-checking bench for the fault and event flag block
`timescale 1ns/1ps
`default_nettype none
module backup_fault_event_logic_bench import bfe_pkg::*;;
    logic core_clk, rst, ena_pin, in_ocp_cmp, in_ovp_cmp, bus_short_cmp;
    logic bus_low_cmp, rev_current_cmp, str_low_cmp, str_drop_cmp, str_ov_cmp;
    logic str_ov_release_cmp, str_buck_off_cmp, bus_por_fall_cmp, tj_125_cmp;
    logic tj_100_cmp, tj_150_cmp, por_done_in, meas_active_in, meas_done_in;
    logic adc_done_in, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, rbs, sds, buck, bmp, boost, ramp;
    logic alloff, bpg, spg, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] ilim;
    logic [4:0] ovth;
    int fail_count = 0;
    int cmp_count = 0;

    // short counts keep the pre-charge and soft-start waits brief
    bfe_fault_ctrl #(.PRECHARGE_CYC(20), .SS_CYC(10)) bfe_fault_ctrl_i (
        .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ena_pin(ena_pin),
        .in_ocp_cmp(in_ocp_cmp), .in_ovp_cmp(in_ovp_cmp),
        .bus_short_cmp(bus_short_cmp), .bus_low_cmp(bus_low_cmp),
        .rev_current_cmp(rev_current_cmp), .str_low_cmp(str_low_cmp),
        .str_drop_cmp(str_drop_cmp), .str_ov_cmp(str_ov_cmp),
        .str_ov_release_cmp(str_ov_release_cmp),
        .str_buck_off_cmp(str_buck_off_cmp),
        .bus_por_fall_cmp(bus_por_fall_cmp), .tj_125_cmp(tj_125_cmp),
        .tj_100_cmp(tj_100_cmp), .tj_150_cmp(tj_150_cmp),
        .por_done_in(por_done_in), .meas_active_in(meas_active_in),
        .meas_done_in(meas_done_in), .adc_done_in(adc_done_in),
        .reverse_blocking_switch(rbs), .storage_disconnect_switch(sds),
        .buck_mode(buck), .buck_max_peak(bmp), .boost_en(boost),
        .input_current_limit(ilim), .current_ramp(ramp),
        .storage_overvoltage_threshold(ovth), .all_off(alloff),
        .bus_power_good(bpg), .storage_power_good(spg), .int_out(irq));

    bfe_host bfe_host_i (
        .clk(core_clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task rc(input logic [7:0] a, input logic [31:0] e);
        bfe_host_i.read(a, d, resp);
        chk(d, e);
    endtask : rc

    task wr(input logic [7:0] a, input logic [31:0] v);
        bfe_host_i.write(a, v, resp);
    endtask : wr

    // ends on an edge; reads there see the flops before they update
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    task conclude();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // hang guard, well past the expected few hundred cycles
    initial begin
        repeat (30000) @(posedge core_clk);
        fail_count++;
        conclude();
    end

    initial begin
        {in_ocp_cmp, in_ovp_cmp, bus_short_cmp, bus_low_cmp, rev_current_cmp,
         str_low_cmp, str_drop_cmp, str_ov_cmp, str_ov_release_cmp,
         str_buck_off_cmp, bus_por_fall_cmp, tj_125_cmp, tj_150_cmp,
         por_done_in, meas_active_in, meas_done_in, adc_done_in} = '0;
        {rst, ena_pin, tj_100_cmp} = 3'b111;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rc(LIMIT_SETUP_OFS, 32'(LIMIT_SETUP_RST));
        rc(EVENT_MASK_OFS, 32'(EVENT_MASK_RST));
        rc(OV_THRESHOLD_OFS, 32'(OV_THRESHOLD_RST));
        rc(8'h18, 32'h0);
        chk(32'(resp), 32'(RESP_SLVERR));
        chk(32'(ilim), 32'h0);
        por_done_in <= 1'b1;
        wr(EVENT_MASK_OFS, 32'h04);
        adc_done_in <= 1'b1;
        cyc(1);
        adc_done_in <= 1'b0;
        cyc(3);
        rc(EVENT_FLAG_OFS, 32'h04);
        chk(32'(irq), 32'h0);
        wr(EVENT_MASK_OFS, 32'h00);
        cyc(2);
        chk(32'(irq), 32'h1);
        meas_done_in <= 1'b1;
        cyc(1);
        meas_done_in <= 1'b0;
        cyc(3);
        rc(EVENT_FLAG_OFS, 32'h0c);
        wr(EVENT_FLAG_OFS, 32'h04);
        cyc(2);
        chk(32'(irq), 32'h1);
        wr(EVENT_FLAG_OFS, 32'h08);
        cyc(2);
        chk(32'(irq), 32'h0);
        // over-current, then the flag must outlive its cause
        in_ocp_cmp <= 1'b1;
        cyc(6);
        chk({rbs, buck, bpg, irq}, 32'h5);
        in_ocp_cmp <= 1'b0;
        cyc(6);
        rc(EVENT_FLAG_OFS, 32'h40);
        wr(EVENT_FLAG_OFS, 32'h40);
        // reverse current is ignored until its enable bit is set
        rev_current_cmp <= 1'b1;
        cyc(6);
        rc(EVENT_FLAG_OFS, 32'h00);
        wr(SPECIAL_FUNCTION_OFS, 32'h40);
        cyc(6);
        rc(EVENT_FLAG_OFS, 32'h10);
        chk(32'(rbs), 32'h0);
        rc(SYSTEM_STATUS_OFS, 32'h00);
        rev_current_cmp <= 1'b0;
        wr(EVENT_FLAG_OFS, 32'h10);
        wr(LIMIT_SETUP_OFS, 32'ha9);
        in_ovp_cmp <= 1'b1;
        cyc(6);
        rc(EVENT_FLAG_OFS, 32'h80);
        chk({ilim, rbs, buck}, 32'h15);
        in_ovp_cmp <= 1'b0;
        wr(EVENT_FLAG_OFS, 32'h80);
        cyc(34); // restart must reach normal run first
        bus_short_cmp <= 1'b1;
        cyc(6);
        chk({rbs, buck, bpg}, 32'h2);
        bus_short_cmp <= 1'b0;
        // warning clear refused while still above 100 degrees
        {tj_125_cmp, tj_100_cmp} <= 2'b10;
        cyc(6);
        rc(EVENT_FLAG_OFS, 32'h02);
        tj_150_cmp <= 1'b1;
        cyc(6);
        chk(32'(rbs), 32'h0);
        tj_150_cmp <= 1'b0;
        wr(EVENT_FLAG_OFS, 32'h03);
        rc(EVENT_FLAG_OFS, 32'h03);
        tj_125_cmp <= 1'b0;
        cyc(6);
        wr(EVENT_FLAG_OFS, 32'h03);
        rc(EVENT_FLAG_OFS, 32'h02);
        tj_100_cmp <= 1'b1;
        cyc(6);
        wr(EVENT_FLAG_OFS, 32'h02);
        rc(EVENT_FLAG_OFS, 32'h00);
        str_ov_cmp <= 1'b1;
        cyc(6);
        chk(32'(boost), 32'h0);
        rc(SYSTEM_STATUS_OFS, 32'h0d);
        wr(OV_THRESHOLD_OFS, 32'h0a);
        cyc(2);
        chk(32'(ovth), 32'h0a);
        chk({sds, spg}, 32'h3);
        str_low_cmp <= 1'b1;
        cyc(6);
        chk({sds, spg}, 32'h0);
        rc(EVENT_FLAG_OFS, 32'h20);
        str_low_cmp <= 1'b0;
        cyc(6);
        chk({sds, spg, rbs}, 32'h0);
        conclude();
    end
endmodule : backup_fault_event_logic_bench
`default_nettype wire
